/* design/rx_baseband_consts.svh */
// Constants for the receive baseband filter and demodulator.
// Assumes a 10 MHz reference clock and an AXI4-Lite register port.
// Notes on behaviour
// - Channel filter is a sixteen-coefficient FIR on I and Q samples.
// - FSK bandwidth is crystal over mantissa times two to exponent plus two.
// - OOK bandwidth uses exponent plus three, half the FSK value.
// - Offset-cancel cutoff code sets 16 percent, halving per step to 0.125.
// - Offset-cancel cutoff resets to code 010, four percent of bandwidth.
// - OOK runs low-IF at half bandwidth, oscillator offset by that amount.
// - Image-reject complex filter bypassed whenever modulation select is FSK.
// - Strength value steps half a decibel per least significant bit.
// - Each strength acquisition completes within two bit periods.
// - Strength value readable only once it exceeds the programmed limit.
// - Gain calibration with injected signal runs during synthesizer start-up.
// - Vector rotation gives phase and amplitude from I and Q samples.
// - FSK demodulator serves FSK, GFSK, MSK, GMSK; index 0.5 to 10.
// - FSK demodulator output routes to the bit synchronizer.
// - OOK demodulator compares strength to threshold chosen by select field.
// - Peak mode threshold is tracked peak less six decibels.
// - Peak decays one step per decay period during zero or no signal.
// - Decaying peak never falls below the floor threshold.
// - Fixed mode compares against the floor threshold directly.
// - Average mode compares against running strength average.
`ifndef RX_BASEBAND_CONSTS_SVH
`define RX_BASEBAND_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MODULATION 8'h00
`define OFS_BANDWIDTH 8'h04
`define OFS_ONOFF_PEAK 8'h08
`define OFS_STRENGTH_LIMIT 8'h0C
`define OFS_STRENGTH 8'h10
`define OFS_CONTROL 8'h14
`define OFS_BITRATE 8'h18
`define OFS_COEF_BASE 8'h40
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MOD_LSB 0
`define EXP_LSB 0
`define MANT_LSB 3
`define DCC_LSB 5
`define STEP_LSB 0
`define PERIOD_LSB 3
`define TSEL_LSB 6
`define FLOOR_LSB 8
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MODULATION 2'h0
`define RST_EXP 3'h5
`define RST_MANT 2'h1
`define RST_DCC 3'h2
`define RST_STEP 3'h0
`define RST_PERIOD 3'h0
`define RST_TSEL 2'h1
`define RST_FLOOR 8'h0C
`define RST_LIMIT 8'hE4
`define RST_BITRATE 16'h0064
// ----------------------------------------------------------------
// Fixed figures
// ----------------------------------------------------------------
`define PEAK_DROP_DB_X2 8'h0C
`define CAL_TIME_NS 2000
`define CAL_CYCLES ((`CAL_TIME_NS + 99) / 100)
`endif

/* design/rx_baseband_pkg.sv */
// Types shared by the receive baseband filter and demodulator.
// Assumes the constants header is included by users as well.
package rx_baseband_pkg;
    typedef enum logic [1:0] {MOD_FSK = 2'b00, MOD_OOK = 2'b01} modulation_t;
    typedef enum logic [1:0] {
        TH_FIXED = 2'b00,
        TH_PEAK = 2'b01,
        TH_AVERAGE = 2'b10
    } threshold_t;
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } iq_sample_t;
    typedef struct packed {
        logic [2:0] offset_cancel_cutoff;
        logic [1:0] filter_mantissa;
        logic [2:0] filter_exponent;
    } bandwidth_t;
    typedef struct packed {
        logic [7:0] floor_threshold;
        logic [1:0] onoff_threshold_select;
        logic [2:0] peak_decay_period;
        logic [2:0] peak_decay_step;
    } onoff_cfg_t;
endpackage

/* design/rx_baseband_filter_demod.sv */
// Receive baseband: channel FIR, offset cancel, strength, demodulators.
// Assumes decimated I/Q samples with a one-cycle valid, AXI4-Lite config.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rx_baseband_consts.svh"
module rx_baseband_filter_demod
    import rx_baseband_pkg::*;
#(
    parameter int TAPS = 16,
    parameter int SW = 16
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire iq_sample_t sample_i,
    input wire logic sample_valid_i,
    input wire logic synth_start_i,
    output logic cal_inject_o,
    output logic cal_done_o,
    output logic [23:0] lo_offset_o,
    output logic complex_bypass_o,
    output logic demod_bit_o,
    output logic demod_valid_o
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (TAPS != 16 || SW < 8 || SW > 16) begin : g_bad
        $error("unsupported filter size");
    end

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    modulation_t modulation_select;
    bandwidth_t bw;
    onoff_cfg_t ook;
    logic [7:0] signal_strength_limit;
    logic [15:0] bitrate_div;
    logic [15:0] coef [TAPS];
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Bus handshake: accept address and data in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
    wire have_aw = aw_held || s_axi_awvalid;
    wire have_w = w_held || s_axi_wvalid;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire coef_sel_w = (wa >= `OFS_COEF_BASE) && (wa < 8'h80);
    wire known_w = coef_sel_w || (wa <= `OFS_BITRATE && wa[1:0] == 2'h0);

    // Byte-lane merge shared by all writable registers except the strength limit, which takes byte 0 only
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    wire [31:0] cur_bw = {24'h0, bw};
    wire [31:0] cur_ook = {16'h0, ook};
    wire [31:0] mg_bw = merge(cur_bw, wd, ws);
    wire [31:0] mg_ook = merge(cur_ook, wd, ws);
    wire [31:0] mg_mod = merge({30'h0, modulation_select}, wd, ws);
    wire [31:0] mg_rate = merge({16'h0, bitrate_div}, wd, ws);
    wire [31:0] mg_coef = merge({16'h0, coef[wa[5:2]]}, wd, ws);

    // Write channel and configuration registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            modulation_select <= MOD_FSK;
            bw <= '{`RST_DCC, `RST_MANT, `RST_EXP};
            ook <= '{`RST_FLOOR, `RST_TSEL, `RST_PERIOD, `RST_STEP};
            signal_strength_limit <= `RST_LIMIT;
            bitrate_div <= `RST_BITRATE;
            for (int k = 0; k < TAPS; k++) begin
                coef[k] <= 16'h0000;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready && !do_write) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_write) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_w ? 2'h0 : 2'h2;
                case (wa)
                    `OFS_MODULATION: modulation_select <= modulation_t'(mg_mod[1:0]);
                    `OFS_BANDWIDTH: bw <= mg_bw[7:0];
                    `OFS_ONOFF_PEAK: ook <= mg_ook[15:0];
                    `OFS_STRENGTH_LIMIT: if (ws[0]) signal_strength_limit <= wd[7:0];
                    `OFS_BITRATE: bitrate_div <= mg_rate[15:0];
                    default: begin
                        if (coef_sel_w) begin
                            coef[wa[5:2]] <= mg_coef[15:0];
                        end
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bandwidth decode
    // ----------------------------------------------------------------
    // Mantissa value and divisor exponent, FSK plus two, OOK plus three
    function automatic logic [4:0] mant_value(input logic [1:0] m);
        case (m)
            2'b00: mant_value = 5'd16;
            2'b01: mant_value = 5'd20;
            2'b10: mant_value = 5'd24;
            default: mant_value = 5'd24;
        endcase
    endfunction
    wire [4:0] mant = mant_value(bw.filter_mantissa);
    wire [3:0] shift = {1'b0, bw.filter_exponent} +
        ((modulation_select == MOD_OOK) ? 4'd3 : 4'd2);
    // Decimation ratio: channel_bandwidth = crystal_frequency / decim
    wire [15:0] decim = 16'(mant) << shift;
    // Low-IF offset: half of OOK bandwidth, in units of crystal/2^16
    wire [23:0] if_step = 24'(24'h10000 / {8'h0, decim} >> 1);
    assign lo_offset_o = (modulation_select == MOD_OOK) ? if_step : 24'h0;
    assign complex_bypass_o = (modulation_select == MOD_FSK);

    // ----------------------------------------------------------------
    // Channel FIR, offset cancel
    // ----------------------------------------------------------------
    logic signed [SW-1:0] di [TAPS], dq [TAPS];
    logic signed [39:0] acc_i, acc_q;
    always_comb begin
        acc_i = '0;
        acc_q = '0;
        for (int k = 0; k < TAPS; k++) begin
            acc_i = acc_i + 40'(di[k] * $signed(coef[k]));
            acc_q = acc_q + 40'(dq[k] * $signed(coef[k]));
        end
    end
    logic signed [23:0] fi, fq, dc_i, dc_q;
    // Cutoff shift: code 0 is 16 percent, each step halves
    wire [3:0] dc_k = 4'd3 + 4'(bw.offset_cancel_cutoff);
    wire signed [23:0] ci = fi - dc_i;
    wire signed [23:0] cq = fq - dc_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int k = 0; k < TAPS; k++) begin
                di[k] <= '0;
                dq[k] <= '0;
            end
            fi <= '0; fq <= '0; dc_i <= '0; dc_q <= '0;
        end else if (sample_valid_i) begin
            di[0] <= sample_i.i[SW-1:0];
            dq[0] <= sample_i.q[SW-1:0];
            for (int k = 1; k < TAPS; k++) begin
                di[k] <= di[k-1];
                dq[k] <= dq[k-1];
            end
            fi <= acc_i[39:16];
            fq <= acc_q[39:16];
            dc_i <= dc_i + (ci >>> dc_k);
            dc_q <= dc_q + (cq >>> dc_k);
        end
    end

    // ----------------------------------------------------------------
    // Vector rotation: magnitude and phase
    // ----------------------------------------------------------------
    // Iterative rotation, 12 steps per sample
    logic signed [25:0] cx, cy;
    logic signed [15:0] ph, phase, phase_prev;
    logic [25:0] amplitude;
    logic [3:0] it;
    logic new_vec;
    function automatic logic [15:0] atan_tab(input logic [3:0] i);
        case (i)
            4'd0: atan_tab = 16'h2000; 4'd1: atan_tab = 16'h12E4;
            4'd2: atan_tab = 16'h09FB; 4'd3: atan_tab = 16'h0511;
            4'd4: atan_tab = 16'h028B; 4'd5: atan_tab = 16'h0146;
            4'd6: atan_tab = 16'h00A3; 4'd7: atan_tab = 16'h0051;
            4'd8: atan_tab = 16'h0029; 4'd9: atan_tab = 16'h0014;
            4'd10: atan_tab = 16'h000A; default: atan_tab = 16'h0005;
        endcase
    endfunction
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cx <= '0; cy <= '0; ph <= '0; it <= 4'hF;
            phase <= '0; phase_prev <= '0; amplitude <= '0; new_vec <= 1'b0;
        end else begin
            new_vec <= 1'b0;
            if (sample_valid_i) begin
                cx <= ci[23] ? -26'(ci) : 26'(ci);
                cy <= ci[23] ? -26'(cq) : 26'(cq);
                ph <= ci[23] ? 16'h8000 : 16'h0000;
                it <= 4'h0;
            end else if (it < 4'd12) begin
                cx <= cy[25] ? cx - (cy >>> it) : cx + (cy >>> it);
                cy <= cy[25] ? cy + (cx >>> it) : cy - (cx >>> it);
                ph <= cy[25] ? ph - atan_tab(it) : ph + atan_tab(it);
                it <= it + 4'h1;
            end else if (it == 4'd12) begin
                phase_prev <= phase;
                phase <= ph;
                amplitude <= cx;
                new_vec <= 1'b1;
                it <= 4'hF;
            end
        end
    end

    // ----------------------------------------------------------------
    // Strength, 0.5 dB per count
    // ----------------------------------------------------------------
    // Log2 estimate: leading one times 6 dB plus 2 mantissa bits
    logic [4:0] lead;
    always_comb begin
        lead = 5'd0;
        for (int b = 0; b < 26; b++) begin
            if (amplitude[b]) lead = 5'(b);
        end
    end
    wire [1:0] frac = (lead >= 5'd2) ? 2'(amplitude >> (lead - 5'd2)) : 2'd0;
    wire [8:0] db_wide = 9'(lead) * 9'd12 + {6'h0, frac, 1'b0} + {7'h0, frac};
    wire [7:0] inst_db = db_wide[8] ? 8'hFF : db_wide[7:0]; // Saturate near full scale
    // Bit period counter; strength averaged over two bit periods
    logic [16:0] bit_cnt;
    logic [15:0] strength_acc;
    logic [7:0] strength_now, signal_strength_value, strength_avg;
    logic [7:0] n_acc;
    wire bit_tick = (bit_cnt == 17'({bitrate_div, 1'b0}));
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt <= '0; strength_acc <= '0; n_acc <= '0;
            strength_now <= '0; signal_strength_value <= '0; strength_avg <= '0;
        end else begin
            bit_cnt <= bit_tick ? 17'h0 : bit_cnt + 17'h1;
            if (new_vec) strength_now <= inst_db;
            if (bit_tick) begin
                strength_acc <= '0;
                n_acc <= '0;
                if (n_acc != 8'h0) begin
                    strength_now <= 8'(strength_acc / {8'h0, n_acc});
                end
                // Held back until above limit, so stale noise never shows
                if (strength_now > signal_strength_limit)
                    signal_strength_value <= strength_now;
            end else if (new_vec && n_acc != 8'hFF) begin
                strength_acc <= strength_acc + {8'h0, inst_db};
                n_acc <= n_acc + 8'h1;
            end
            // Running average for DC-free OOK
            if (new_vec) strength_avg <= 8'((11'(strength_avg) * 11'd7 + 11'(inst_db)) >> 3);
        end
    end

    // ----------------------------------------------------------------
    // Demodulators
    // ----------------------------------------------------------------
    // FSK: sign of phase step gives the bit
    wire signed [15:0] dphi = phase - phase_prev;
    logic [7:0] peak;
    logic [10:0] decay_cnt;
    wire [10:0] decay_lim = 11'h8 << ook.peak_decay_period;
    wire [7:0] peak_thr = (9'(peak) > 9'(ook.floor_threshold) + 9'(`PEAK_DROP_DB_X2))
        ? peak - `PEAK_DROP_DB_X2 : ook.floor_threshold;
    wire [7:0] thr = (ook.onoff_threshold_select == TH_PEAK) ? peak_thr
        : (ook.onoff_threshold_select == TH_AVERAGE) ? strength_avg
        : ook.floor_threshold;
    wire ook_bit = inst_db > thr;
    wire [7:0] dec = {4'h0, ook.peak_decay_step, 1'b0} + 8'h2;
    wire [7:0] next_peak = (9'(peak) > 9'(ook.floor_threshold) + 9'(dec)) ? peak - dec
        : ook.floor_threshold;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            peak <= '0; decay_cnt <= '0; demod_bit_o <= 1'b0; demod_valid_o <= 1'b0;
        end else begin
            demod_valid_o <= new_vec;
            if (new_vec) begin
                demod_bit_o <= (modulation_select == MOD_FSK) ? !dphi[15] : ook_bit;
                if (inst_db > peak) begin
                    peak <= inst_db;
                    decay_cnt <= '0;
                end else if (!ook_bit) begin
                    decay_cnt <= decay_cnt + 11'h1;
                    if (decay_cnt >= decay_lim) begin
                        peak <= next_peak;
                        decay_cnt <= '0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Gain calibration at synthesizer start-up
    // ----------------------------------------------------------------
    logic [7:0] cal_cnt;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_cnt <= '0; cal_inject_o <= 1'b0; cal_done_o <= 1'b0;
        end else if (synth_start_i) begin
            cal_cnt <= 8'(`CAL_CYCLES);
            cal_inject_o <= 1'b1;
            cal_done_o <= 1'b0;
        end else if (cal_cnt != 8'h0) begin
            cal_cnt <= cal_cnt - 8'h1;
            cal_inject_o <= (cal_cnt != 8'h1);
            cal_done_o <= (cal_cnt == 8'h1);
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    logic [31:0] rd;
    always_comb begin
        case (s_axi_araddr)
            `OFS_MODULATION: rd = {30'h0, modulation_select};
            `OFS_BANDWIDTH: rd = cur_bw;
            `OFS_ONOFF_PEAK: rd = cur_ook;
            `OFS_STRENGTH_LIMIT: rd = {24'h0, signal_strength_limit};
            `OFS_STRENGTH: rd = {24'h0, signal_strength_value};
            `OFS_CONTROL: rd = {14'h0, cal_done_o, cal_inject_o, decim};
            `OFS_BITRATE: rd = {16'h0, bitrate_div};
            default: rd = (s_axi_araddr >= `OFS_COEF_BASE && s_axi_araddr < 8'h80)
                ? {16'h0, coef[s_axi_araddr[5:2]]} : 32'h0;
        endcase
    end
    wire known_r = s_axi_araddr <= `OFS_BITRATE
        || (s_axi_araddr >= `OFS_COEF_BASE && s_axi_araddr < 8'h80);
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= (known_r && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* tb/rx_baseband_monitor.sv */
// Port checker for the receive baseband block.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module rx_baseband_monitor (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic sample_valid_i,
    input wire logic synth_start_i,
    input wire logic cal_inject_o,
    input wire logic cal_done_o,
    input wire logic [23:0] lo_offset_o,
    input wire logic complex_bypass_o,
    input wire logic demod_bit_o,
    input wire logic demod_valid_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // Keying side effects
    property p_byp; complex_bypass_o |-> lo_offset_o == 24'h0; endproperty
    a_byp: assert property (p_byp) else $error("offset present with bypass");
    property p_ook; !complex_bypass_o |-> lo_offset_o != 24'h0; endproperty
    a_ook: assert property (p_ook) else $error("no offset in on-off keying");
    // Demodulator timing
    property p_dlat; sample_valid_i |-> ##15 demod_valid_o; endproperty
    a_dlat: assert property (p_dlat) else $error("demod latency wrong");
    property p_dpul; demod_valid_o |=> !demod_valid_o; endproperty
    a_dpul: assert property (p_dpul) else $error("demod valid too long");
    property p_bit; $changed(demod_bit_o) |-> demod_valid_o; endproperty
    a_bit: assert property (p_bit) else $error("bit moved without valid");
    // Calibration sequence
    property p_cal; $rose(synth_start_i) |-> ##[1:2] cal_inject_o; endproperty
    a_cal: assert property (p_cal) else $error("calibration not started");
    property p_cdone; $fell(cal_inject_o) |-> cal_done_o; endproperty
    a_cdone: assert property (p_cdone) else $error("calibration not done");
    // Read channel, the only way to see the strength value
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind rx_baseband_filter_demod rx_baseband_monitor rx_baseband_monitor_i (.*);

/* tb/tx_model.sv */
// Distant transmitter: one I/Q sample every 16 clocks.
// Assumes the bench sets the bit and the keying kind.
`timescale 1ns/1ps
module tx_model
    import rx_baseband_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bit_i,
    input wire logic fsk_i,
    output iq_sample_t sample_o,
    output logic valid_o
);
    logic [3:0] cnt;
    logic [1:0] ph;
    logic [15:0] amp;
    iq_sample_t next_s;
    // FSK turns a quarter per sample, sense by bit; OOK keys amplitude
    assign amp = ph[1] ? 16'hC000 : 16'h4000;
    assign next_s = fsk_i ? (ph[0] ? {16'h0, amp} : {amp, 16'h0}) : {1'b0, bit_i, 30'h0};
    // Data toggles off the valid cycle, so nothing stale can pass as a sample
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 4'h0;
            ph <= 2'h0;
            valid_o <= 1'b0;
            sample_o <= '0;
        end else begin
            cnt <= cnt + 4'h1;
            valid_o <= (cnt == 4'hF);
            sample_o <= (cnt == 4'hF) ? next_s : ~sample_o;
            if (cnt == 4'hF) ph <= bit_i ? ph + 2'h1 : ph - 2'h1;
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the receive baseband block.
// Assumes the transmitter model feeds samples; registers via AXI4-Lite.
`timescale 1ns/1ps
`include "rx_baseband_consts.svh"
module tb
    import rx_baseband_pkg::*;
;
    logic ref_clk_i, resetn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    iq_sample_t sample_i;
    logic sample_valid_i, synth_start_i, cal_inject_o, cal_done_o, complex_bypass_o;
    logic demod_bit_o, demod_valid_o, tx_bit, tx_fsk;
    logic [23:0] lo_offset_o;
    int fail_count, checks_done;
    rx_baseband_filter_demod rx_baseband_filter_demod_i (.*);
    tx_model tx_model_i (.clk_i(ref_clk_i), .rstn_i(resetn_i), .bit_i(tx_bit), .fsk_i(tx_fsk),
        .sample_o(sample_i), .valid_o(sample_valid_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b = 1'b0;
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge ref_clk_i);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            @(posedge ref_clk_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        logic ar, ok = 1'b0;
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!ok) begin
            @(negedge ref_clk_i);
            ar = s_axi_arready;
            ok = s_axi_rvalid;
            v = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge ref_clk_i);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        chk(32'(complex_bypass_o), 32'h1);
        rd(`OFS_BANDWIDTH, d, r);
        chk(d, 32'h4D);
        rd(`OFS_ONOFF_PEAK, d, r);
        chk(d, 32'h0C40);
        rd(8'h20, d, r);
        chk(32'(r), 32'h2);
    endtask
    // Mantissa 16 keeps the half-bandwidth offset exact for every exponent
    task t_bw;
        wr(`OFS_MODULATION, 32'(MOD_OOK));
        for (int e = 0; e < 8; e++) begin
            wr(`OFS_BANDWIDTH, 32'(e * 33));
            rd(`OFS_BANDWIDTH, d, r);
            chk(d, 32'(e * 33));
            chk(32'(lo_offset_o), 32'(256 >> e));
        end
    endtask
    task automatic t_cal;
        int n = 0;
        synth_start_i <= 1'b1;
        @(posedge ref_clk_i);
        synth_start_i <= 1'b0;
        repeat (40) begin
            @(negedge ref_clk_i);
            if (cal_inject_o === 1'b1) n++;
        end
        chk(32'(n), 32'd20);
        rd(`OFS_CONTROL, d, r);
        chk(32'(d[17:16]), 32'h2);
    endtask
    task t_strength;
        logic [31:0] s0;
        tx_bit <= 1'b1;
        wr(`OFS_STRENGTH_LIMIT, 32'hFF);
        rd(`OFS_STRENGTH, s0, r);
        repeat (200) @(posedge ref_clk_i);
        rd(`OFS_STRENGTH, d, r);
        chk(d, s0);
        wr(`OFS_STRENGTH_LIMIT, 32'h0);
        repeat (200) @(posedge ref_clk_i);
        rd(`OFS_STRENGTH, d, r);
        chk(32'(d != s0), 32'h1);
    endtask
    // Eight samples per bit; floor sits above the offset-residue zero level
    task automatic t_demod(input logic [1:0] m, input logic [1:0] ts);
        logic [7:0] pat;
        pat = 8'hCA;
        tx_fsk <= (m == MOD_FSK);
        wr(`OFS_MODULATION, 32'(m));
        wr(`OFS_ONOFF_PEAK, {16'h0, 8'h8C, ts, 6'h0});
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk_i);
            tx_bit <= pat[i];
            repeat (8) begin
                do @(negedge ref_clk_i); while (demod_valid_o !== 1'b1);
            end
            if (i < 7) chk(32'(demod_bit_o), 32'(pat[i]));
        end
    endtask
    initial begin
        {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {synth_start_i, tx_bit, tx_fsk, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        wr(`OFS_COEF_BASE, 32'h7FFF);
        rd(`OFS_COEF_BASE, d, r);
        chk(d, 32'h7FFF);
        t_bw();
        t_cal();
        t_strength();
        t_demod(MOD_FSK, TH_PEAK);
        t_demod(MOD_OOK, TH_FIXED);
        t_demod(MOD_OOK, TH_PEAK);
        t_demod(MOD_OOK, TH_AVERAGE);
        results();
    end
    // Whole run needs about 4700 cycles
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        fail_count++;
        results();
    end
endmodule
